/* rtl/reclose_gating_pkg.sv */
// constants and types shared by the reclose gating and retention block
// What this block does
// - shot-1 block bits 0..3 stop high-set, external, low-set, earth-fault sources
// - shot-2/3 block bits 4..7 stop the same four sources, same order
// - a shot block bit at one stops its source; all reset to zero
// - stage block bits 0..4 block low, high, inst, low-ef, high-ef at shot 1
// - stage block bits 5..9 block the same stages at shots 2 and 3; reset zero
// - a stage block holds until cutout, reclaim or lockout, whichever first
// - inhibit bits 0..3 inhibit reclose from inst, high-ef, thermal, unbalance
// - inhibit bit 4 clears stored indications on the reclose command
// - first trip indication stays shown until the hold timer expires
// - hold time in minutes up to 998, reset value 60
// - hold time 999 keeps the shown indication until a manual clear
// - hold timer drives only the display, never protection behaviour
// - five retention bits reset to one; bit 0 keeps indications and leds
// - bits 1..4 keep recorder, events, recorded values, clock with battery
// - all retention bits zero turns battery supervision off
// - group checksum is the sum of weights two to the n minus one
package reclose_gating_pkg;

  // reset values of the switch groups and hold time
  localparam logic [7:0] SHOT_BLOCK_RESET  = 8'h00;
  localparam logic [9:0] STAGE_BLOCK_RESET = 10'h000;
  localparam logic [4:0] INHIBIT_RESET     = 5'h0F;
  localparam logic [4:0] RETAIN_RESET      = 5'h1F;
  localparam logic [9:0] HOLD_RESET        = 10'h03C;
  localparam logic [9:0] HOLD_MANUAL       = 10'h3E7;

  // register selects on the setting port
  localparam logic [2:0] SEL_SHOT_BLOCK  = 3'h0;
  localparam logic [2:0] SEL_STAGE_BLOCK = 3'h1;
  localparam logic [2:0] SEL_INHIBIT     = 3'h2;
  localparam logic [2:0] SEL_RETAIN      = 3'h3;
  localparam logic [2:0] SEL_HOLD_TIME   = 3'h4;

  // field positions
  localparam int SHOT1_LSB       = 0;
  localparam int SHOT23_LSB      = 4;
  localparam int STAGE1_LSB      = 0;
  localparam int STAGE23_LSB     = 5;
  localparam int INH_CLEAR_BIT   = 4;
  localparam int RET_IND_BIT     = 0;
  localparam int RET_DIST_BIT    = 1;
  localparam int RET_EVENT_BIT   = 2;
  localparam int RET_RECORD_BIT  = 3;
  localparam int RET_CLOCK_BIT   = 4;

  // shot numbers from the sequencer
  localparam logic [1:0] SHOT_ONE = 2'h1;

  // timing: one second and one minute from the 200 MHz clock
  localparam longint SECOND_NS          = 1000000000;
  localparam longint CLK_PERIOD_NS      = 5;
  localparam int unsigned CYCLES_PER_SECOND = int'(SECOND_NS / CLK_PERIOD_NS);
  localparam int unsigned SECONDS_PER_MINUTE = 60;

  // indication display state
  typedef enum logic [2:0] {
    IND_EMPTY = 3'b001,
    IND_HOLD  = 3'b010,
    IND_OPEN  = 3'b100
  } ind_state_t;

endpackage

/* rtl/tick_divider.sv */
// counts step pulses and emits one tick pulse every div steps
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int unsigned DIV = 60
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic restart,
  input  wire logic step,
  output logic      tick
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } div_state_t;

  div_state_t state_reg;
  div_state_t state_next;

  // restart wins so a fresh load always gets a full period
  always_comb begin
    state_next      = state_reg;
    state_next.tick = 1'b0;
    if (restart) begin
      state_next.cnt = 32'h0000_0000;
    end else if (step) begin
      if (state_reg.cnt == 32'(DIV - 1)) begin
        state_next.cnt  = 32'h0000_0000;
        state_next.tick = 1'b1;
      end else begin
        state_next.cnt = state_reg.cnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick = state_reg.tick;

endmodule
`default_nettype wire

/* rtl/reclose_gating.sv */
// switch groups, shot and stage gating, indication hold timer, retention
`timescale 1ns/1ps
`default_nettype none
module reclose_gating #(
  parameter int unsigned CYCLES_PER_SECOND = reclose_gating_pkg::CYCLES_PER_SECOND
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  // setting port from front panel or serial link
  input  wire logic       cfg_wr,
  input  wire logic [2:0] cfg_sel,
  input  wire logic [9:0] cfg_wdata,
  output logic      [9:0] cfg_rd_data,
  // sequencer status
  input  wire logic       sequence_active,
  input  wire logic [1:0] next_shot,
  input  wire logic       shot_started,
  input  wire logic [1:0] shot_num,
  input  wire logic       cutout_elapsed,
  input  wire logic       reclaim_elapsed,
  input  wire logic       lockout,
  input  wire logic       reclose_cmd,
  // shot initiation sources
  input  wire logic       high_set_oc_trip,
  input  wire logic       ext_reclose_init,
  input  wire logic       low_set_oc_start,
  input  wire logic       earth_fault_start,
  output logic      [3:0] shot_init_ok,
  // reclose inhibit sources
  input  wire logic       inst_oc_trip,
  input  wire logic       high_set_earth_fault_stage_trip,
  input  wire logic       thermal_alarm,
  input  wire logic       unbalance_trip,
  output logic            reclose_inhibit,
  // stage trip blocking toward the protection stages
  output logic      [4:0] stage_trip_block,
  // trip indication display
  input  wire logic       trip_event,
  input  wire logic [2:0] trip_code,
  input  wire logic       manual_clear,
  output logic            ind_valid,
  output logic      [2:0] ind_code,
  output logic            ind_replace_ok,
  output logic            indications_clear,
  // retention selection
  input  wire logic       battery_ok,
  output logic            keep_indications,
  output logic            keep_disturbance,
  output logic            keep_events,
  output logic            keep_recorded,
  output logic            keep_clock,
  output logic            battery_supervision_en
);

  typedef struct packed {
    logic [7:0]                     shot_block;
    logic [9:0]                     stage_block;
    logic [4:0]                     inhibit;
    logic [4:0]                     retain;
    logic [9:0]                     hold_time;
    logic [7:0]                     shot_block_act;
    logic [9:0]                     stage_block_act;
    logic [4:0]                     stage_hold;
    logic [3:0]                     init_ok;
    logic                           inhibit_out;
    logic [9:0]                     rd_data;
    reclose_gating_pkg::ind_state_t ind_state;
    logic [2:0]                     code;
    logic [9:0]                     minutes_left;
    logic                           manual_only;
    logic                           clear_pulse;
    logic [4:0]                     keep;
    logic                           batt_sup;
  } gate_state_t;

  gate_state_t state_reg;
  gate_state_t state_next;

  logic second_tick;
  logic minute_tick;
  logic timer_load;

  // restart the dividers whenever a fresh hold period is started
  tick_divider #(
    .DIV (CYCLES_PER_SECOND)
  ) second_div (
    .clk     (clk),
    .rst_b   (rst_b),
    .restart (timer_load),
    .step    (1'b1),
    .tick    (second_tick)
  );

  tick_divider #(
    .DIV (reclose_gating_pkg::SECONDS_PER_MINUTE)
  ) minute_div (
    .clk     (clk),
    .rst_b   (rst_b),
    .restart (timer_load),
    .step    (second_tick),
    .tick    (minute_tick)
  );

  logic [3:0] init_src;
  logic [3:0] init_mask;
  logic [4:0] stage_mask;
  logic [3:0] inh_src;
  logic       seq_clear;
  logic       stage_release;
  logic       show_new;

  // source vectors in switch order
  assign init_src = {earth_fault_start, low_set_oc_start, ext_reclose_init, high_set_oc_trip};
  assign inh_src  = {unbalance_trip, thermal_alarm, high_set_earth_fault_stage_trip,
                     inst_oc_trip};

  // shot 1 uses the low nibble, shots 2 and 3 the high one
  assign init_mask = (next_shot == reclose_gating_pkg::SHOT_ONE) ?
    state_reg.shot_block_act[reclose_gating_pkg::SHOT1_LSB +: 4] :
    state_reg.shot_block_act[reclose_gating_pkg::SHOT23_LSB +: 4];

  assign stage_mask = (shot_num == reclose_gating_pkg::SHOT_ONE) ?
    state_reg.stage_block_act[reclose_gating_pkg::STAGE1_LSB +: 5] :
    state_reg.stage_block_act[reclose_gating_pkg::STAGE23_LSB +: 5];

  // first of cutout, reclaim or lockout ends the stage blocking
  assign stage_release = cutout_elapsed | reclaim_elapsed | lockout;

  // clearing of indications on the reclose command
  assign seq_clear = reclose_cmd & state_reg.inhibit[reclose_gating_pkg::INH_CLEAR_BIT];

  // a new trip is shown when nothing is held or the hold has run out
  assign show_new = trip_event &
                    ((state_reg.ind_state != reclose_gating_pkg::IND_HOLD) |
                     seq_clear | manual_clear);

  assign timer_load = show_new;

  always_comb begin
    state_next             = state_reg;
    state_next.clear_pulse = 1'b0;

    // setting writes; each group keeps only the low bits that fit its width, read back unchanged
    if (cfg_wr) begin
      case (cfg_sel)
        reclose_gating_pkg::SEL_SHOT_BLOCK: begin
          state_next.shot_block = cfg_wdata[7:0];
        end
        reclose_gating_pkg::SEL_STAGE_BLOCK: begin
          state_next.stage_block = cfg_wdata;
        end
        reclose_gating_pkg::SEL_INHIBIT: begin
          state_next.inhibit = cfg_wdata[4:0];
        end
        reclose_gating_pkg::SEL_RETAIN: begin
          state_next.retain = cfg_wdata[4:0];
        end
        reclose_gating_pkg::SEL_HOLD_TIME: begin
          state_next.hold_time = cfg_wdata;
        end
        default: begin
          state_next.hold_time = state_reg.hold_time;
        end
      endcase
    end

    // readback: each bit weighs two to its index, so the value is the checksum
    case (cfg_sel)
      reclose_gating_pkg::SEL_SHOT_BLOCK: begin
        state_next.rd_data = {2'h0, state_reg.shot_block};
      end
      reclose_gating_pkg::SEL_STAGE_BLOCK: begin
        state_next.rd_data = state_reg.stage_block;
      end
      reclose_gating_pkg::SEL_INHIBIT: begin
        state_next.rd_data = {5'h00, state_reg.inhibit};
      end
      reclose_gating_pkg::SEL_RETAIN: begin
        state_next.rd_data = {5'h00, state_reg.retain};
      end
      reclose_gating_pkg::SEL_HOLD_TIME: begin
        state_next.rd_data = state_reg.hold_time;
      end
      default: begin
        state_next.rd_data = 10'h000;
      end
    endcase

    // working copies follow the settings only between sequences, so a
    // write in mid-sequence cannot change the shot already being decided
    if (!sequence_active) begin
      state_next.shot_block_act  = state_reg.shot_block;
      state_next.stage_block_act = state_reg.stage_block;
    end

    // a set switch removes its source from shot initiation
    state_next.init_ok = init_src & ~init_mask;

    // any enabled inhibit source inhibits the reclose function
    state_next.inhibit_out = |(inh_src & state_reg.inhibit[3:0]);

    // stage blocking: a new shot start wins over a release in the same cycle
    if (shot_started) begin
      state_next.stage_hold = stage_mask;
    end else if (stage_release) begin
      state_next.stage_hold = 5'h00;
    end

    // indication display; it feeds no protection signal at all
    case (state_reg.ind_state)
      reclose_gating_pkg::IND_EMPTY: begin
        state_next.ind_state = reclose_gating_pkg::IND_EMPTY;
      end
      reclose_gating_pkg::IND_HOLD: begin
        if (!state_reg.manual_only && state_reg.minutes_left == 10'h000) begin
          state_next.ind_state = reclose_gating_pkg::IND_OPEN;
        end else if (!state_reg.manual_only && minute_tick) begin
          state_next.minutes_left = state_reg.minutes_left - 10'h001;
        end
      end
      reclose_gating_pkg::IND_OPEN: begin
        state_next.ind_state = reclose_gating_pkg::IND_OPEN;
      end
      default: begin
        state_next.ind_state = reclose_gating_pkg::IND_EMPTY;
      end
    endcase

    // clears empty the display and drop the stored code; a trip in the
    // same cycle is still shown
    if (manual_clear || seq_clear) begin
      state_next.ind_state   = reclose_gating_pkg::IND_EMPTY;
      state_next.code        = 3'h0;
      state_next.clear_pulse = 1'b1;
    end

    if (show_new) begin
      state_next.ind_state    = reclose_gating_pkg::IND_HOLD;
      state_next.code         = trip_code;
      state_next.minutes_left = state_reg.hold_time;
      state_next.manual_only  = (state_reg.hold_time >= reclose_gating_pkg::HOLD_MANUAL);
    end

    // retention selections; bits past the first need a charged battery
    state_next.keep[reclose_gating_pkg::RET_IND_BIT] =
      state_reg.retain[reclose_gating_pkg::RET_IND_BIT];
    state_next.keep[reclose_gating_pkg::RET_DIST_BIT] =
      state_reg.retain[reclose_gating_pkg::RET_DIST_BIT] & battery_ok;
    state_next.keep[reclose_gating_pkg::RET_EVENT_BIT] =
      state_reg.retain[reclose_gating_pkg::RET_EVENT_BIT] & battery_ok;
    state_next.keep[reclose_gating_pkg::RET_RECORD_BIT] =
      state_reg.retain[reclose_gating_pkg::RET_RECORD_BIT] & battery_ok;
    state_next.keep[reclose_gating_pkg::RET_CLOCK_BIT] =
      state_reg.retain[reclose_gating_pkg::RET_CLOCK_BIT] & battery_ok;

    // supervision is off only when no retention bit is set, bit 0 included
    state_next.batt_sup = |state_reg.retain;
  end

  // register the whole state; settings take their documented defaults
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg.shot_block      <= reclose_gating_pkg::SHOT_BLOCK_RESET;
      state_reg.stage_block     <= reclose_gating_pkg::STAGE_BLOCK_RESET;
      state_reg.inhibit         <= reclose_gating_pkg::INHIBIT_RESET;
      state_reg.retain          <= reclose_gating_pkg::RETAIN_RESET;
      state_reg.hold_time       <= reclose_gating_pkg::HOLD_RESET;
      state_reg.shot_block_act  <= reclose_gating_pkg::SHOT_BLOCK_RESET;
      state_reg.stage_block_act <= reclose_gating_pkg::STAGE_BLOCK_RESET;
      state_reg.stage_hold      <= 5'h00;
      state_reg.init_ok         <= 4'h0;
      state_reg.inhibit_out     <= 1'b0;
      state_reg.rd_data         <= 10'h000;
      state_reg.ind_state       <= reclose_gating_pkg::IND_EMPTY;
      state_reg.code            <= 3'h0;
      state_reg.minutes_left    <= 10'h000;
      state_reg.manual_only     <= 1'b0;
      state_reg.clear_pulse     <= 1'b0;
      state_reg.keep            <= 5'h00;
      state_reg.batt_sup        <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state flops
  assign cfg_rd_data            = state_reg.rd_data;
  assign shot_init_ok           = state_reg.init_ok;
  assign reclose_inhibit        = state_reg.inhibit_out;
  assign stage_trip_block       = state_reg.stage_hold;
  assign ind_valid              = (state_reg.ind_state != reclose_gating_pkg::IND_EMPTY);
  assign ind_code               = state_reg.code;
  assign ind_replace_ok         = (state_reg.ind_state != reclose_gating_pkg::IND_HOLD);
  assign indications_clear      = state_reg.clear_pulse;
  assign keep_indications       = state_reg.keep[reclose_gating_pkg::RET_IND_BIT];
  assign keep_disturbance       = state_reg.keep[reclose_gating_pkg::RET_DIST_BIT];
  assign keep_events            = state_reg.keep[reclose_gating_pkg::RET_EVENT_BIT];
  assign keep_recorded          = state_reg.keep[reclose_gating_pkg::RET_RECORD_BIT];
  assign keep_clock             = state_reg.keep[reclose_gating_pkg::RET_CLOCK_BIT];
  assign battery_supervision_en = state_reg.batt_sup;

endmodule
`default_nettype wire

/* verif/seq_model.sv */
// sequencer side model: one shot per go, then a reclose command and a release
`timescale 1ns/1ps
`default_nettype none
module seq_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       go,
  input  wire logic [1:0] shot,
  input  wire logic       slow,
  output logic            sequence_active,
  output logic            shot_started,
  output logic      [1:0] shot_num,
  output logic            reclose_cmd,
  output logic            lockout,
  output logic            reclaim_elapsed
);
  int cnt;
  // slow shots end by reclaim, fast ones by lockout
  always @(posedge clk) begin
    shot_started    <= 1'b0;
    reclose_cmd     <= 1'b0;
    lockout         <= 1'b0;
    reclaim_elapsed <= 1'b0;
    if (!rst_b) begin
      sequence_active <= 1'b0;
      shot_num        <= 2'h0;
      cnt             <= 0;
    end else if (go && !sequence_active) begin
      sequence_active <= 1'b1;
      shot_started    <= 1'b1;
      shot_num        <= shot;
      cnt             <= slow ? 12 : 3;
    end else if (sequence_active) begin
      cnt <= cnt - 1;
      if (cnt == 2) reclose_cmd <= 1'b1;
      if (cnt == 1) begin
        sequence_active <= 1'b0;
        reclaim_elapsed <= slow;
        lockout         <= !slow;
      end
    end
  end
endmodule
`default_nettype wire

/* verif/reclose_gating_monitor.sv */
// port-level checker for the reclose gating block
`timescale 1ns/1ps
`default_nettype none
module reclose_gating_monitor (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       high_set_oc_trip,
  input wire logic       earth_fault_start,
  input wire logic [3:0] shot_init_ok,
  input wire logic       shot_started,
  input wire logic       cutout_elapsed,
  input wire logic       reclaim_elapsed,
  input wire logic       lockout,
  input wire logic [4:0] stage_trip_block,
  input wire logic       trip_event,
  input wire logic [2:0] trip_code,
  input wire logic       manual_clear,
  input wire logic       reclose_cmd,
  input wire logic       ind_valid,
  input wire logic [2:0] ind_code,
  input wire logic       ind_replace_ok,
  input wire logic       indications_clear,
  input wire logic       battery_ok,
  input wire logic       keep_indications,
  input wire logic       keep_events,
  input wire logic       battery_supervision_en
);
  // one clock domain, so clocking and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_shot_high_gate: assert property (!high_set_oc_trip |=> !shot_init_ok[0])
    else $error("shot start without high-set source");
  a_shot_ef_gate: assert property (!earth_fault_start |=> !shot_init_ok[3])
    else $error("shot start without earth-fault source");
  a_stage_release: assert property ((cutout_elapsed || reclaim_elapsed || lockout)
    && !shot_started |=> stage_trip_block == 5'h00) else $error("stage block not released");
  a_stage_hold: assert property (!shot_started && !cutout_elapsed && !reclaim_elapsed
    && !lockout |=> $stable(stage_trip_block)) else $error("stage block changed");
  a_trip_shown: assert property (trip_event && (!ind_valid || ind_replace_ok || manual_clear)
    |=> ind_valid && ind_code == $past(trip_code)) else $error("trip not shown");
  a_hold_keep: assert property (ind_valid && !ind_replace_ok && !manual_clear && !reclose_cmd
    |=> ind_valid && $stable(ind_code)) else $error("held indication replaced");
  a_clear_pulse: assert property (manual_clear && !trip_event
    |=> indications_clear && !ind_valid) else $error("manual clear ignored");
  a_clear_cause: assert property (indications_clear && !$past(manual_clear)
    |-> $past(reclose_cmd)) else $error("clear without cause");
  a_keep_battery: assert property (keep_events |-> $past(battery_ok))
    else $error("events kept without battery");
  a_sup_follow: assert property (keep_indications |-> battery_supervision_en)
    else $error("supervision off with retention set");
endmodule

bind reclose_gating reclose_gating_monitor i_mon (
  .clk(clk), .rst_b(rst_b), .high_set_oc_trip(high_set_oc_trip),
  .earth_fault_start(earth_fault_start), .shot_init_ok(shot_init_ok),
  .shot_started(shot_started), .cutout_elapsed(cutout_elapsed),
  .reclaim_elapsed(reclaim_elapsed), .lockout(lockout), .stage_trip_block(stage_trip_block),
  .trip_event(trip_event), .trip_code(trip_code), .manual_clear(manual_clear),
  .reclose_cmd(reclose_cmd), .ind_valid(ind_valid), .ind_code(ind_code),
  .ind_replace_ok(ind_replace_ok), .indications_clear(indications_clear),
  .battery_ok(battery_ok), .keep_indications(keep_indications), .keep_events(keep_events),
  .battery_supervision_en(battery_supervision_en)
);
`default_nettype wire

/* verif/reclose_gating_bench.sv */
// self-checking bench for the reclose gating block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; $display("Error at %0t: got %h expected %h", $time, a, b); end end
module reclose_gating_bench;
  logic       clk, rst_b, cfg_wr, go, slow, trip_event, manual_clear, battery_ok, cutout;
  logic       sequence_active, shot_started, reclaim_elapsed, lockout, reclose_cmd;
  logic       reclose_inhibit, ind_valid, ind_replace_ok, indications_clear, sup;
  logic [1:0] next_shot, shot, shot_num;
  logic [2:0] cfg_sel, trip_code, ind_code;
  logic [3:0] src, isrc, shot_init_ok;
  logic [4:0] stage_trip_block, keep;
  logic [9:0] cfg_wdata, cfg_rd_data, m, r, e_w;
  logic [9:0] obs [0:6];
  logic [9:0] exp_q [$];
  int         src_q [$];
  int         checks, failures, seed, n, i, k, s_w;
  localparam logic [9:0] RV [0:5] = '{10'h000, 10'h000, 10'h00F, 10'h01F, 10'h03C, 10'h000};
  localparam logic [9:0] WM [0:4] = '{10'h0FF, 10'h3FF, 10'h01F, 10'h01F, 10'h3FF};

  // one minute is 120 cycles with two cycles a second
  reclose_gating #(.CYCLES_PER_SECOND(2)) i_dut (
    .clk(clk), .rst_b(rst_b), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata),
    .cfg_rd_data(cfg_rd_data), .sequence_active(sequence_active), .next_shot(next_shot),
    .shot_started(shot_started), .shot_num(shot_num), .cutout_elapsed(cutout),
    .reclaim_elapsed(reclaim_elapsed), .lockout(lockout), .reclose_cmd(reclose_cmd),
    .high_set_oc_trip(src[0]), .ext_reclose_init(src[1]), .low_set_oc_start(src[2]),
    .earth_fault_start(src[3]), .shot_init_ok(shot_init_ok), .inst_oc_trip(isrc[0]),
    .high_set_earth_fault_stage_trip(isrc[1]), .thermal_alarm(isrc[2]),
    .unbalance_trip(isrc[3]), .reclose_inhibit(reclose_inhibit),
    .stage_trip_block(stage_trip_block), .trip_event(trip_event), .trip_code(trip_code),
    .manual_clear(manual_clear), .ind_valid(ind_valid), .ind_code(ind_code),
    .ind_replace_ok(ind_replace_ok), .indications_clear(indications_clear),
    .battery_ok(battery_ok), .keep_indications(keep[0]), .keep_disturbance(keep[1]),
    .keep_events(keep[2]), .keep_recorded(keep[3]), .keep_clock(keep[4]),
    .battery_supervision_en(sup));
  seq_model i_seq (.clk(clk), .rst_b(rst_b), .go(go), .shot(shot), .slow(slow),
    .sequence_active(sequence_active), .shot_started(shot_started), .shot_num(shot_num),
    .reclose_cmd(reclose_cmd), .lockout(lockout), .reclaim_elapsed(reclaim_elapsed));

  // watched outputs, widened to one compare width
  assign obs[0] = cfg_rd_data;
  assign obs[1] = {6'h00, shot_init_ok};
  assign obs[2] = {9'h000, reclose_inhibit};
  assign obs[3] = {5'h00, stage_trip_block};
  assign obs[4] = {5'h00, indications_clear, ind_valid, ind_code};
  assign obs[5] = {4'h0, keep, sup};
  assign obs[6] = {9'h000, ind_replace_ok};

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // every pending note, oldest first, against its output, half a cycle after the edge so flops have settled
  always @(negedge clk) begin
    while (src_q.size() > 0) begin
      s_w = src_q.pop_front();
      e_w = exp_q.pop_front();
      `CHK(obs[s_w], e_w)
    end
  end

  task automatic tick(int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic note(int s, logic [9:0] v);
    src_q.push_back(s);
    exp_q.push_back(v);
  endtask
  task automatic wr(logic [2:0] s, logic [9:0] d);
    cfg_wr <= 1'b1;
    cfg_sel <= s;
    cfg_wdata <= d;
    tick(1);
    cfg_wr <= 1'b0;
    tick(1);
  endtask
  task automatic rd(logic [2:0] s, logic [9:0] e);
    cfg_sel <= s;
    tick(2);
    note(0, e);
  endtask
  task automatic trip(logic [2:0] c);
    trip_event <= 1'b1;
    trip_code <= c;
    tick(1);
    trip_event <= 1'b0;
    trip_code <= ~c;
    tick(1);
  endtask
  task automatic clr;
    manual_clear <= 1'b1;
    tick(1);
    manual_clear <= 1'b0;
    note(4, 10'h010);
    tick(1);
  endtask
  task automatic shot_go(logic [1:0] s, logic sl);
    go <= 1'b1;
    shot <= s;
    slow <= sl;
    tick(1);
    go <= 1'b0;
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    {rst_b, cfg_wr, go, slow, trip_event, manual_clear, battery_ok, cutout} = 8'h00;
    {next_shot, shot, cfg_sel, trip_code, src, isrc, cfg_wdata} = 28'h0000000;
    checks = 0;
    failures = 0;
    seed = 2;
    tick(6);
    rst_b <= 1'b1;
    tick(1);
    for (i = 0; i < 6; i++) rd(i[2:0], RV[i]);
    note(5, 10'h003);
    $display("test reset values done");
    for (i = 0; i < 4; i++) begin
      m = (i == 0) ? 10'h000 : 10'($random(seed));
      r = 10'($random(seed));
      for (k = 0; k < 6; k++) begin
        wr(k[2:0], m);
        rd(k[2:0], (k < 5) ? (m & WM[k]) : 10'h000);
      end
      src <= r[3:0];
      isrc <= r[7:4];
      next_shot <= i[1:0];
      battery_ok <= r[8];
      tick(2);
      note(1, {6'h00, r[3:0] & ~((i == 1) ? m[3:0] : m[7:4])});
      note(2, {9'h000, |(r[7:4] & m[3:0])});
      note(5, {4'h0, m[4:1] & {4{r[8]}}, m[0], |m[4:0]});
    end
    $display("test switch groups done");
    // third pass ends its blocking early by a cutout pulse
    for (i = 0; i < 3; i++) begin
      m = 10'($random(seed));
      wr(3'h1, m);
      shot_go(i ? 2'h2 : 2'h1, i != 0);
      tick(2);
      note(3, {5'h00, i ? m[9:5] : m[4:0]});
      if (i) begin
        wr(3'h1, ~m);
        note(3, {5'h00, m[9:5]});
      end
      if (i == 2) begin
        cutout <= 1'b1;
        tick(1);
        cutout <= 1'b0;
        note(3, 10'h000);
      end
      tick(i ? 10 : 4);
      note(3, 10'h000);
    end
    $display("test stage blocking done");
    wr(3'h2, 10'h00F);
    wr(3'h4, 10'h001);
    trip(3'h3);
    note(4, 10'h00B);
    trip(3'h5);
    note(4, 10'h00B);
    tick(100);
    note(6, 10'h000);
    note(3, 10'h000);
    n = 0;
    while (ind_replace_ok !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    // a hold that never runs out counts as a mismatch
    if (n == 100) begin
      failures++;
    end
    trip(3'h5);
    note(4, 10'h00D);
    clr();
    wr(3'h4, 10'h3E7);
    trip(3'h6);
    tick(300);
    trip(3'h2);
    note(4, 10'h00E);
    note(6, 10'h000);
    clr();
    $display("test indication hold done");
    wr(3'h2, 10'h010);
    trip(3'h1);
    note(4, 10'h009);
    shot_go(2'h1, 1'b0);
    tick(3);
    note(4, 10'h010);
    tick(1);
    note(4, 10'h000);
    tick(4);
    $display("test reclose clear done");
    close_out();
  end
endmodule
`default_nettype wire
